// ---- design/rxm_out_mux.v ----
// receive output multiplexer: quadrature nibble bus, if word bus, frame marker
// assumes converter samples arrive from logic on SYS_CLK_IN; one sample set per four cycles
//
// What this block does
// - The quadrature bus and the frame marker update on every rising clock edge; the if word buses on every second edge at most.
// - The frame marker flags the first nibble of every quadrature symbol.
// - One I and Q symbol goes out over four consecutive cycles, four bits per cycle.
// - Nibble order is I upper, I lower, Q upper, Q lower, and the receiver rebuilds in that order.
// - A 10-bit and a 12-bit sample are each presented at most once every two cycles, and only when IF_VALID_IN is high.
// - With quadrature converters powered up, the marker rides on every second 10-bit word.
`include "rxm_map.vh"
module rxm_out_mux #(
    parameter QW    = `RXM_QUAD_W,
    parameter DEPTH = `RXM_FIFO_DEPTH,
    parameter AW    = `RXM_FIFO_AW
) (
    input  wire            SYS_CLK_IN,
    input  wire            RESET_N_IN,
    input  wire            IQ_POWER_DOWN_IN,
    input  wire            IQ_VALID_IN,
    output wire            IQ_READY_OUT,
    input  wire [QW-1:0]   I_SAMPLE_IN,
    input  wire [QW-1:0]   Q_SAMPLE_IN,
    input  wire            IF_VALID_IN,
    input  wire [9:0]      IF10_SAMPLE_IN,
    input  wire [11:0]     IF12_SAMPLE_IN,
    output reg  [3:0]      QUADRATURE_RECEIVE_BUS_OUT,
    output reg             FRAME_SYNC_OUT,
    output reg  [9:0]      IF10_BUS_OUT,
    output reg  [11:0]     IF12_BUS_OUT,
    output reg             IF_PHASE_OUT
);
    localparam ST_IH = 4'b0001;
    localparam ST_IL = 4'b0010;
    localparam ST_QH = 4'b0100;
    localparam ST_QL = 4'b1000;

    reg  [3:0]      st_q;
    reg  [3:0]      st_d;
    reg  [2*QW-1:0] sym_q;
    reg  [3:0]      nib_d;
    reg             pd_meta_q;
    reg             pd_q;
    reg             if_ph_q;
    wire            fifo_valid;
    wire [2*QW-1:0] fifo_data;
    wire            take;
    wire            frame_start;
    wire            if_take;

    function [3:0] upper_nib;
        input [QW-1:0] s;
        upper_nib = s[QW-1:QW-4];
    endfunction

    function [3:0] lower_nib;
        input [QW-1:0] s;
        lower_nib = s[3:0];
    endfunction

    // one-hot walk through the four nibble slots of a symbol
    function [3:0] next_st;
        input [3:0] s;
        begin
            case (s)
                ST_IH:   next_st = ST_IL;
                ST_IL:   next_st = ST_QH;
                ST_QH:   next_st = ST_QL;
                ST_QL:   next_st = ST_IH;
                default: next_st = ST_IH;
            endcase
        end
    endfunction

    // i and q enter as one word so a symbol never mixes two instants
    rxm_fifo #(
        .WIDTH (2*QW),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .clk_in       (SYS_CLK_IN),
        .rst_n_in     (RESET_N_IN),
        .wr_valid_in  (IQ_VALID_IN),
        .wr_ready_out (IQ_READY_OUT),
        .wr_data_in   ({I_SAMPLE_IN, Q_SAMPLE_IN}),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (take),
        .rd_data_out  (fifo_data)
    );

    always @*
    begin
        st_d = next_st(st_q);
    end

    // new symbol only at the start of a four-cycle frame
    assign frame_start = (st_d == ST_IH);
    assign take        = frame_start & ~pd_q;
    // if words are taken on every second edge only
    assign if_take     = ~if_ph_q & IF_VALID_IN;

    // nibble of the next cycle, chosen from its state
    always @*
    begin
        case (st_d)
            ST_IH:   nib_d = fifo_valid ? upper_nib(fifo_data[2*QW-1:QW]) : upper_nib(sym_q[2*QW-1:QW]);
            ST_IL:   nib_d = lower_nib(sym_q[2*QW-1:QW]);
            ST_QH:   nib_d = upper_nib(sym_q[QW-1:0]);
            ST_QL:   nib_d = lower_nib(sym_q[QW-1:0]);
            default: nib_d = 4'h0;
        endcase
    end

    // power-down is a slow pin level, synchronised before use
    always @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            pd_meta_q <= 1'b1;
            pd_q      <= 1'b1;
        end
        else
        begin
            pd_meta_q <= IQ_POWER_DOWN_IN;
            pd_q      <= pd_meta_q;
        end
    end

    // frame position keeps running while asleep, so the cadence never slips
    always @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            st_q <= ST_QL;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // taking edges are the odd ones after release, which lines the marker up with a word
    always @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            if_ph_q <= 1'b0;
        end
        else
        begin
            if_ph_q <= ~if_ph_q;
        end
    end

    // repeat last symbol on underrun, keeps the frame cadence
    always @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            sym_q <= {(2*QW){1'b0}};
        end
        else if (take & fifo_valid)
        begin
            sym_q <= fifo_data;
        end
    end

    // bus parks at zero while the quadrature converters sleep
    always @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            QUADRATURE_RECEIVE_BUS_OUT <= 4'h0;
        end
        else
        begin
            QUADRATURE_RECEIVE_BUS_OUT <= pd_q ? 4'h0 : nib_d;
        end
    end

    // marker rides with the i upper nibble, only when awake
    always @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            FRAME_SYNC_OUT <= 1'b0;
        end
        else
        begin
            FRAME_SYNC_OUT <= ~pd_q & frame_start;
        end
    end

    // high in the first cycle of each if word slot
    always @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            IF_PHASE_OUT <= 1'b0;
        end
        else
        begin
            IF_PHASE_OUT <= ~if_ph_q;
        end
    end

    // if words change every second edge at most, held in between
    always @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            IF10_BUS_OUT <= 10'h000;
            IF12_BUS_OUT <= 12'h000;
        end
        else if (if_take)
        begin
            IF10_BUS_OUT <= IF10_SAMPLE_IN;
            IF12_BUS_OUT <= IF12_SAMPLE_IN;
        end
    end
endmodule

// ---- design/rxm_map.vh ----
// constants for the receive output multiplexer
// assumes inclusion by bare name from the design files
`ifndef RXM_MAP_VH
`define RXM_MAP_VH
`define RXM_QUAD_W        8
`define RXM_IF10_W        10
`define RXM_IF12_W        12
`define RXM_NIB_W         4
`define RXM_NIBS_PER_SYM  4
`define RXM_FIFO_DEPTH    16
`define RXM_FIFO_AW       4
`define RXM_CLK_PERIOD_NS 10
`endif

// ---- design/rxm_fifo.v ----
// synchronous fifo of flip-flops with valid/ready on both sides
// assumes a single clock and asynchronous active-low reset
module rxm_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_in,
    input  wire             rst_n_in,
    input  wire             wr_valid_in,
    output wire             wr_ready_out,
    input  wire [WIDTH-1:0] wr_data_in,
    output wire             rd_valid_out,
    input  wire             rd_ready_in,
    output wire [WIDTH-1:0] rd_data_out
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wp_q;
    reg [AW-1:0]    rp_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
    assign rd_valid_out = (cnt_q != {(AW+1){1'b0}});
    assign push         = wr_valid_in & wr_ready_out;
    assign pop          = rd_valid_out & rd_ready_in;
    assign rd_data_out  = mem_q[rp_q];

    always @(posedge clk_in)
    begin
        if (push)
            mem_q[wp_q] <= wr_data_in;
    end

    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
            if (pop)
                rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
            if (push & ~pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// ---- verif/rxm_out_mux_chk.sv ----
// port checker for the receive output multiplexer
// assumes it is bound onto rxm_out_mux, one clock domain
module rxm_out_mux_chk (
    input wire        SYS_CLK_IN,
    input wire        RESET_N_IN,
    input wire        IQ_POWER_DOWN_IN,
    input wire        IF_VALID_IN,
    input wire [9:0]  IF10_SAMPLE_IN,
    input wire [11:0] IF12_SAMPLE_IN,
    input wire [3:0]  QUADRATURE_RECEIVE_BUS_OUT,
    input wire        FRAME_SYNC_OUT,
    input wire [9:0]  IF10_BUS_OUT,
    input wire [11:0] IF12_BUS_OUT,
    input wire        IF_PHASE_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    sequence s_frame;
        !FRAME_SYNC_OUT[*3] ##1 FRAME_SYNC_OUT;
    endsequence
    sequence s_pd;
        IQ_POWER_DOWN_IN[*4];
    endsequence
    a_sync_period: assert property (FRAME_SYNC_OUT ##1 !IQ_POWER_DOWN_IN |-> s_frame) else $error("sync period");
    a_sync_pair: assert property (FRAME_SYNC_OUT |-> IF_PHASE_OUT)
        else $error("sync not on every second if word");
    a_if_take: assert property (!IF_PHASE_OUT && $past(IF_PHASE_OUT) && IF_VALID_IN |=> IF_PHASE_OUT
        && IF10_BUS_OUT == $past(IF10_SAMPLE_IN) && IF12_BUS_OUT == $past(IF12_SAMPLE_IN))
        else $error("if word");
    a_if_pulse: assert property (IF_PHASE_OUT |=> !IF_PHASE_OUT) else $error("if phase");
    a_if_hold: assert property (IF_PHASE_OUT |=> $stable(IF10_BUS_OUT) && $stable(IF12_BUS_OUT))
        else $error("if hold");
    a_if_idle: assert property (!IF_PHASE_OUT && !IF_VALID_IN |=> $stable(IF10_BUS_OUT) && $stable(IF12_BUS_OUT))
        else $error("if word without valid");
    a_pd_sync: assert property (s_pd |-> !FRAME_SYNC_OUT) else $error("sync in power down");
    a_pd_bus: assert property (s_pd |-> QUADRATURE_RECEIVE_BUS_OUT == 4'h0) else $error("bus in power down");
endmodule
bind rxm_out_mux rxm_out_mux_chk chk (.SYS_CLK_IN, .RESET_N_IN, .IQ_POWER_DOWN_IN, .IF_VALID_IN,
    .IF10_SAMPLE_IN, .IF12_SAMPLE_IN, .QUADRATURE_RECEIVE_BUS_OUT, .FRAME_SYNC_OUT, .IF10_BUS_OUT,
    .IF12_BUS_OUT, .IF_PHASE_OUT);

// ---- verif/rxm_rx_model.sv ----
// downstream receiver model: rebuilds i/q symbols from the nibble bus
// assumes the marker flags the i upper nibble
module rxm_rx_model (
    input  wire         clk_in,
    input  wire  [3:0]  nib_in,
    input  wire         sync_in,
    output logic [15:0] sym_out,
    output logic        sym_v_out = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] acc_q = 12'h0;
    logic [1:0]  cnt_q = 2'h0;
    logic        got_q = 1'b0;
    always @(posedge clk_in)
    begin
        sym_v_out <= got_q && cnt_q == 2'h3;
        sym_out   <= {acc_q, nib_in};
        acc_q     <= {acc_q[7:0], nib_in};
        cnt_q     <= sync_in ? 2'h1 : cnt_q + 2'h1;
        // a frame that opened without the marker is ignored
        got_q     <= sync_in | (got_q & (cnt_q != 2'h3));
    end
endmodule

// ---- verif/rxm_out_mux_tb_top.sv ----
// top testbench for the receive output multiplexer
// assumes design, checker and receiver model compiled first
module rxm_out_mux_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst_n = 1'b0, pd = 1'b1, iq_v = 1'b0, full_seen = 1'b0, if_v = 1'b0;
    logic [7:0]  i_s = 8'h0, q_s = 8'h0;
    logic [9:0]  s10 = 10'h0, o10;
    logic [11:0] s12 = 12'h0, o12;
    logic [3:0]  nib;
    logic        sync, rdy, ph, sym_v;
    logic [15:0] sym, exp_q[$];
    logic [21:0] if_q[$];
    integer      seed = 32'hce4e01e3, err_total = 0, tests_run = 0, n_ok = 0;
    rxm_out_mux dut (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .IQ_POWER_DOWN_IN(pd), .IQ_VALID_IN(iq_v),
        .IQ_READY_OUT(rdy), .I_SAMPLE_IN(i_s), .Q_SAMPLE_IN(q_s), .IF_VALID_IN(if_v), .IF10_SAMPLE_IN(s10),
        .IF12_SAMPLE_IN(s12), .QUADRATURE_RECEIVE_BUS_OUT(nib), .FRAME_SYNC_OUT(sync), .IF10_BUS_OUT(o10),
        .IF12_BUS_OUT(o12), .IF_PHASE_OUT(ph));
    rxm_rx_model rx (.clk_in(clk), .nib_in(nib), .sync_in(sync), .sym_out(sym), .sym_v_out(sym_v));
    initial forever #5 clk = ~clk;
    // words are taken on phase-0 edges; the note is made at that edge
    always @(posedge clk)
    begin
        if (rst_n === 1'b1 && ph === 1'b0 && if_v === 1'b1)
            if_q.push_back({s10, s12});
        {if_v, s10, s12} <= 23'($random(seed));
    end
    always @(negedge clk)
        if (ph === 1'b1 && if_q.size() > 0)
            cmp_if(if_q.pop_front(), {o10, o12});
    task cmp(input logic [15:0] e, input logic [15:0] s, input string n);
        tests_run++;
        if (e !== s)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task cmp_if(input logic [21:0] e, input logic [21:0] s);
        tests_run++;
        if (e !== s)
        begin
            err_total++;
            $display("Error if_word expected %h seen %h", e, s);
        end
    endtask
    task push_sym(input int n);
        repeat (n)
        begin
            {i_s, q_s} <= 16'($random(seed));
            iq_v <= 1'b1;
            @(posedge clk);
            while (rdy !== 1'b1)
            begin
                full_seen = 1'b1;
                @(posedge clk);
            end
            exp_q.push_back({i_s, q_s});
        end
        iq_v <= 1'b0;
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // leading zero frames precede the first push and are not counted
    always @(posedge clk)
        if (sym_v === 1'b1 && exp_q.size() > 0 && (n_ok > 0 || sym !== 16'h0))
        begin
            cmp(exp_q.pop_front(), sym, "symbol");
            n_ok++;
        end
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        pd <= 1'b0;
        repeat (4) @(posedge clk);
        // pushes outpace the drain, so the fifo fills and refuses
        push_sym(40);
        for (int k = 0; k < 400 && exp_q.size() > 0; k++)
            @(posedge clk);
        // asleep: no marker, bus at zero, words wait in the fifo
        pd <= 1'b1;
        repeat (8) @(posedge clk);
        push_sym(4);
        repeat (8) @(posedge clk);
        pd <= 1'b0;
        for (int k = 0; k < 100 && exp_q.size() > 0; k++)
            @(posedge clk);
        cmp(16'h0, 16'(exp_q.size()), "pending");
        cmp(16'h1, {15'h0, full_seen}, "refusal");
        end_of_test;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        err_total++;
        end_of_test;
    end
endmodule
